// >>> charger_opt4_high.sv
`default_nettype none

// What this block does
// R01: Bits 7-5 pick the system rail undervoltage threshold, default code 0.
// R02: Undervoltage trip enters retry mode unless retry is disabled.
// R03: In retry, seven failed restarts inside 90 s latch the charger off.
// R04: Retry-disable bit 2, also word 0x37 bit 10, suppresses retry mode.
// R05: Bits 4-3 select dithering: off, 2, 4 or 6 percent spread.
// R06: Bit 1 enables the input droop alert profile driving throttle alert.
// R07: Bit 0 droop flag is read-only, latched until read, read clears.
// R08: Flag sets when enabled profile fires; host writes to bit 0 ignored.
module charger_opt4_high #(
  parameter logic [63:0] WINDOW_CYCLES = charger_opt4_pkg::WINDOW_CYCLES,
  parameter int          MAX_FAILS     = charger_opt4_pkg::MAX_FAILS
) (
  // Clock and reset
  input  wire  logic       clk_sys,
  input  wire  logic       nrst,
  // Byte register port from the serial slave
  input  wire  logic [7:0] reg_addr,
  input  wire  logic       reg_wr,
  input  wire  logic       reg_rd,
  input  wire  logic [7:0] reg_wdata,
  output logic       [7:0] reg_rdata,
  // Analog and converter events
  input  wire  logic       uvp_trip_pin,
  input  wire  logic       droop_pin,
  input  wire  logic       restart_fail,
  // Configuration and status outputs
  output logic       [2:0] sys_rail_undervolt_threshold,
  output logic       [1:0] dither_sel,
  output logic             retry_active,
  output logic             latch_off,
  output logic             host_throttle_alert
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic uvp_meta_reg, uvp_sync_reg;
  logic droop_meta_reg, droop_sync_reg, droop_last_reg;

  // Two flops per pin, then an edge history on the second
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      uvp_meta_reg   <= 1'b0;
      uvp_sync_reg   <= 1'b0;
      droop_meta_reg <= 1'b0;
      droop_sync_reg <= 1'b0;
      droop_last_reg <= 1'b0;
    end else begin
      uvp_meta_reg   <= uvp_trip_pin;
      uvp_sync_reg   <= uvp_meta_reg;
      droop_meta_reg <= droop_pin;
      droop_sync_reg <= droop_meta_reg;
      droop_last_reg <= droop_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [2:0] thr_reg, thr_next;
  logic [1:0] dith_reg, dith_next;
  logic       retry_dis_reg, retry_dis_next;
  logic       droop_en_reg, droop_en_next;
  logic       droop_flag_reg, droop_flag_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       alert_reg, alert_next;
  logic       hit_main, hit_alias, read_main, droop_fire;

  assign hit_main   = reg_wr && (reg_addr == charger_opt4_pkg::ADDR_OPT4_HIGH);
  assign hit_alias  = reg_wr &&
                      (reg_addr == charger_opt4_pkg::ADDR_RETRY_ALIAS);
  assign read_main  = reg_rd && (reg_addr == charger_opt4_pkg::ADDR_OPT4_HIGH);
  assign droop_fire = droop_en_reg && droop_sync_reg && !droop_last_reg;

  // Next register values, readback and droop flag
  always_comb begin
    thr_next        = thr_reg;
    dith_next       = dith_reg;
    retry_dis_next  = retry_dis_reg;
    droop_en_next   = droop_en_reg;
    droop_flag_next = droop_flag_reg;
    rdata_next      = rdata_reg;
    alert_next      = droop_en_reg && droop_sync_reg;     // see R06
    if (hit_main) begin
      thr_next = reg_wdata[charger_opt4_pkg::THR_MSB:
                           charger_opt4_pkg::THR_LSB];      // see R01
      dith_next = reg_wdata[charger_opt4_pkg::DITH_MSB:
                            charger_opt4_pkg::DITH_LSB];    // see R05
      retry_dis_next =
        reg_wdata[charger_opt4_pkg::RETRY_DIS_BIT];        // see R04
      droop_en_next =
        reg_wdata[charger_opt4_pkg::DROOP_EN_BIT];         // see R06
    end
    if (hit_alias) begin
      retry_dis_next =
        reg_wdata[charger_opt4_pkg::ALIAS_RETRY_BIT];      // see R04
    end
    if (reg_rd) begin
      rdata_next = read_main ?
        {thr_reg, dith_reg, retry_dis_reg, droop_en_reg, droop_flag_reg} :
        8'h00;
    end
    // Read clears, a fresh event in the same cycle wins
    if (read_main) begin
      droop_flag_next = 1'b0;                               // see R07
    end
    if (droop_fire) begin
      droop_flag_next = 1'b1;                               // see R08
    end
  end

  // Register the bank
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      thr_reg        <= charger_opt4_pkg::THR_RST;
      dith_reg       <= charger_opt4_pkg::DITH_RST;
      retry_dis_reg  <= charger_opt4_pkg::RETRY_DIS_RST;
      droop_en_reg   <= charger_opt4_pkg::DROOP_EN_RST;
      droop_flag_reg <= charger_opt4_pkg::DROOP_FLAG_RST;
      rdata_reg      <= 8'h00;
      alert_reg      <= 1'b0;
    end else begin
      thr_reg        <= thr_next;
      dith_reg       <= dith_next;
      retry_dis_reg  <= retry_dis_next;
      droop_en_reg   <= droop_en_next;
      droop_flag_reg <= droop_flag_next;
      rdata_reg      <= rdata_next;
      alert_reg      <= alert_next;
    end
  end

  // ----------------------------------------------------------------
  // Undervoltage retry control
  // ----------------------------------------------------------------
  charger_opt4_pkg::uv_state_e state_reg, state_next;
  logic retry_reg, retry_next;
  logic latch_reg, latch_next;
  logic limit_hit;

  // Restart failures only count while retrying
  fail_window #(
    .MAX_FAILS     (MAX_FAILS),
    .WINDOW_CYCLES (WINDOW_CYCLES)
  ) u_fail_window (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .fail_pulse (restart_fail && (state_reg == charger_opt4_pkg::UV_RETRY)),
    .limit_hit  (limit_hit)
  );

  // Retry state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      charger_opt4_pkg::UV_IDLE: begin
        if (uvp_sync_reg && !retry_dis_reg) begin
          state_next = charger_opt4_pkg::UV_RETRY;          // see R02
        end
      end
      charger_opt4_pkg::UV_RETRY: begin
        if (limit_hit) begin
          state_next = charger_opt4_pkg::UV_LATCHED;        // see R03
        end else if (retry_dis_reg || !uvp_sync_reg) begin
          state_next = charger_opt4_pkg::UV_IDLE;           // see R04
        end
      end
      charger_opt4_pkg::UV_LATCHED: begin
        state_next = charger_opt4_pkg::UV_LATCHED;
      end
      default: begin
        state_next = charger_opt4_pkg::UV_IDLE;
      end
    endcase
    retry_next = (state_next == charger_opt4_pkg::UV_RETRY);
    latch_next = (state_next == charger_opt4_pkg::UV_LATCHED);
  end

  // Register the retry state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= charger_opt4_pkg::UV_IDLE;
      retry_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      retry_reg <= retry_next;
      latch_reg <= latch_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata                    = rdata_reg;
  assign sys_rail_undervolt_threshold = thr_reg;
  assign dither_sel                   = dith_reg;
  assign retry_active                 = retry_reg;
  assign latch_off                    = latch_reg;
  assign host_throttle_alert          = alert_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_main_write;
    hit_main;
  endsequence

  sequence s_droop_event;
    droop_en_reg && droop_sync_reg && !droop_last_reg;
  endsequence

  AST_THR_WRITE: assert property (                          // see R01
    s_main_write |=> thr_reg == $past(reg_wdata[7:5]))
    else $error("threshold field not loaded");

  AST_RETRY_ENTER: assert property (                        // see R02
    (state_reg == charger_opt4_pkg::UV_IDLE) && uvp_sync_reg &&
    !retry_dis_reg |=> retry_active)
    else $error("retry mode not entered on trip");

  AST_LATCH_CAUSE: assert property (                        // see R03
    $rose(latch_off) |-> $past(limit_hit))
    else $error("latch off without failure limit");

  AST_LATCH_HOLD: assert property (                         // see R03
    latch_off |=> latch_off ##1 latch_off)
    else $error("latch off released");

  AST_NO_RETRY_DIS: assert property (                       // see R04
    retry_dis_reg && !limit_hit |=> !retry_active)
    else $error("retry active while disabled");

  AST_ALIAS_WRITE: assert property (                        // see R04
    hit_alias |=> retry_dis_reg == $past(reg_wdata[2]))
    else $error("alias write missed retry disable");

  AST_DITHER_WRITE: assert property (                       // see R05
    s_main_write |=> dither_sel == $past(reg_wdata[4:3]))
    else $error("dither field not loaded");

  AST_ALERT: assert property (                              // see R06
    ##1 host_throttle_alert == $past(droop_en_reg && droop_sync_reg))
    else $error("throttle alert mismatch");

  AST_FLAG_SET: assert property (                           // see R08
    s_droop_event |=> droop_flag_reg)
    else $error("droop flag not set");

  AST_FLAG_CLEAR: assert property (                         // see R07
    read_main && !droop_fire |=> !droop_flag_reg)
    else $error("droop flag not cleared by read");

  AST_FLAG_HOLD: assert property (                          // see R07
    droop_flag_reg && !read_main |=> droop_flag_reg)
    else $error("droop flag lost without read");

endmodule : charger_opt4_high

`default_nettype wire

// >>> charger_opt4_pkg.sv
`default_nettype none

package charger_opt4_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPT4_HIGH   = 8'h3D;
  localparam logic [7:0] ADDR_RETRY_ALIAS = 8'h37;
  localparam int         ALIAS_RETRY_BIT  = 2;   // Bit 10 of the word

  // ----------------------------------------------------------------
  // Field positions in the high byte
  // ----------------------------------------------------------------
  localparam int THR_MSB        = 7;
  localparam int THR_LSB        = 5;
  localparam int DITH_MSB       = 4;
  localparam int DITH_LSB       = 3;
  localparam int RETRY_DIS_BIT  = 2;
  localparam int DROOP_EN_BIT   = 1;
  localparam int DROOP_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] THR_RST        = 3'h0;  // Lowest threshold
  localparam logic [1:0] DITH_RST       = 2'h0;  // Dithering off
  localparam logic       RETRY_DIS_RST  = 1'b0;
  localparam logic       DROOP_EN_RST   = 1'b0;
  localparam logic       DROOP_FLAG_RST = 1'b0;

  // ----------------------------------------------------------------
  // Retry timing
  // ----------------------------------------------------------------
  localparam int          MAX_FAILS     = 7;
  localparam longint      WINDOW_TIME_S = 90;
  localparam longint      CLK_HZ        = 100_000_000;
  localparam logic [63:0] WINDOW_CYCLES = 64'(WINDOW_TIME_S * CLK_HZ);

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DITHER_OFF = 2'b00,
    DITHER_PM2 = 2'b01,
    DITHER_PM4 = 2'b10,
    DITHER_PM6 = 2'b11
  } dither_e;

  typedef enum logic [1:0] {
    UV_IDLE    = 2'b00,
    UV_RETRY   = 2'b01,
    UV_LATCHED = 2'b10
  } uv_state_e;

endpackage : charger_opt4_pkg

`default_nettype wire

// >>> fail_window.sv
`default_nettype none

module fail_window #(
  parameter int          MAX_FAILS     = 7,
  parameter logic [63:0] WINDOW_CYCLES = 64'd9_000_000_000
) (
  // Clock and reset
  input  wire  logic clk_sys,
  input  wire  logic nrst,
  // Failed restart events
  input  wire  logic fail_pulse,
  // Limit reached, sticky until reset
  output logic       limit_hit
);

  logic [63:0] timer_reg, timer_next;
  logic        run_reg, run_next;
  logic [3:0]  count_reg, count_next;
  logic        hit_reg, hit_next;

  // ----------------------------------------------------------------
  // Window opens at the first failure and closes after WINDOW_CYCLES
  // ----------------------------------------------------------------
  always_comb begin
    timer_next = timer_reg;
    run_next   = run_reg;
    count_next = count_reg;
    hit_next   = hit_reg;
    if (run_reg) begin
      if (timer_reg == WINDOW_CYCLES - 64'd1) begin
        run_next   = 1'b0;
        count_next = 4'h0;
      end else begin
        timer_next = timer_reg + 64'd1;
      end
    end
    if (fail_pulse) begin
      if (!run_next) begin
        run_next   = 1'b1;
        timer_next = 64'h0;
        count_next = 4'h1;
      end else begin
        count_next = count_next + 4'h1;
      end
    end
    if (count_next >= 4'(MAX_FAILS)) begin
      hit_next = 1'b1;                              // see R03
    end
  end

  // Register the window state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      timer_reg <= 64'h0;
      run_reg   <= 1'b0;
      count_reg <= 4'h0;
      hit_reg   <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      run_reg   <= run_next;
      count_reg <= count_next;
      hit_reg   <= hit_next;
    end
  end

  assign limit_hit = hit_reg;

  // Limit flag is sticky until reset
  AST_HIT_STICKY: assert property (@(posedge clk_sys) disable iff (!nrst)
    hit_reg |=> hit_reg)                           // see R03
    else $error("failure limit flag dropped");

endmodule : fail_window

`default_nettype wire

// >>> host_model.sv
`default_nettype none

module host_model (
  // Clock
  input  wire  logic       clk_sys,
  // Register port toward the byte register slave
  output logic       [7:0] reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic       [7:0] reg_wdata,
  input  wire  logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // Byte transfers, one-cycle strobe launched off the falling edge
  // ----------------------------------------------------------------
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_addr  = ~a;   // Released lines must not keep the last value
    reg_wdata = ~d;
  endtask : wr_byte

  // Read data is taken one edge after the strobe edge
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(posedge clk_sys);
    #1 q = reg_rdata;
  endtask : rd_byte

endmodule : host_model

`default_nettype wire

// >>> tb_top.sv
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] w;
    logic [2:0] thr;
    logic [1:0] dith;
    logic [7:0] rd;
  } row_s;

  logic       clk_sys = 1'b0;
  logic       nrst    = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic       reg_wr, reg_rd;
  logic       uvp_trip_pin = 1'b0;
  logic       droop_pin    = 1'b0;
  logic       restart_fail = 1'b0;
  logic [2:0] thr;
  logic [1:0] dith;
  logic       retry_active, latch_off, alert;
  int         bad_count   = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  row_s       rows [9] = '{'{8'hFF, 3'h7, 2'h3, 8'hFE},
                           '{8'h2A, 3'h1, 2'h1, 8'h2A},
                           '{8'h4D, 3'h2, 2'h1, 8'h4C},
                           '{8'h75, 3'h3, 2'h2, 8'h74},
                           '{8'h93, 3'h4, 2'h2, 8'h92},
                           '{8'hB1, 3'h5, 2'h2, 8'hB0},
                           '{8'hD8, 3'h6, 2'h3, 8'hD8},
                           '{8'hE3, 3'h7, 2'h0, 8'hE2},
                           '{8'h00, 3'h0, 2'h0, 8'h00}};

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  charger_opt4_high #(.WINDOW_CYCLES(64'd200), .MAX_FAILS(7)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .uvp_trip_pin(uvp_trip_pin),
    .droop_pin(droop_pin), .restart_fail(restart_fail),
    .sys_rail_undervolt_threshold(thr), .dither_sel(dith),
    .retry_active(retry_active), .latch_off(latch_off),
    .host_throttle_alert(alert));

  host_model host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic do_reset;
    @(negedge clk_sys);
    nrst = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
  endtask : do_reset

  // One failed restart, sampled at the next rising edge
  task automatic fail_once;
    @(negedge clk_sys);
    restart_fail = 1'b1;
    @(negedge clk_sys);
    restart_fail = 1'b0;
  endtask : fail_once

  // Bounded wait for retry mode
  task automatic wait_retry;
    for (int i = 0; i < 10 && retry_active !== 1'b1; i++)
      @(negedge clk_sys);
  endtask : wait_retry

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    host.rd_byte(8'h3D, q);
    `CHK("reset byte", 8'h00, q)
    `CHK("reset latch", 1'b0, latch_off)
    // Field table: all threshold and dither codes, bit 0 write ignored
    foreach (rows[i]) begin
      host.wr_byte(8'h3D, rows[i].w);
      @(negedge clk_sys);
      `CHK("threshold", rows[i].thr, thr)
      `CHK("dither", rows[i].dith, dith)
      host.rd_byte(8'h3D, q);
      `CHK("readback", rows[i].rd, q)
    end
    // Unmapped place reads as zero, and a write there leaves 0x3D unchanged
    host.wr_byte(8'h10, 8'hFF);
    host.rd_byte(8'h10, q);
    `CHK("unmapped", 8'h00, q)
    host.rd_byte(8'h3D, q);
    `CHK("no side write", 8'h00, q)
    // Droop with profile off is ignored
    @(negedge clk_sys) droop_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK("alert off", 1'b0, alert)
    droop_pin = 1'b0;
    host.rd_byte(8'h3D, q);
    `CHK("flag off", 8'h00, q)
    // Droop with profile on latches the flag until read
    host.wr_byte(8'h3D, 8'h02);
    @(negedge clk_sys) droop_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK("alert on", 1'b1, alert)
    host.rd_byte(8'h3D, q);
    `CHK("flag set", 8'h03, q)
    host.rd_byte(8'h3D, q);
    `CHK("flag cleared", 8'h02, q)
    @(negedge clk_sys) droop_pin = 1'b0;
    // Alias write disables retry
    host.wr_byte(8'h37, 8'h04);
    host.rd_byte(8'h37, q);
    `CHK("alias read", 8'h00, q)
    host.rd_byte(8'h3D, q);
    `CHK("alias bit", 8'h06, q)
    @(negedge clk_sys) uvp_trip_pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK("retry blocked", 1'b0, retry_active)
    host.wr_byte(8'h37, 8'h00);
    wait_retry();
    `CHK("retry entered", 1'b1, retry_active)
    // Six failures keep retrying, the seventh latches off
    repeat (6) fail_once();
    repeat (3) @(negedge clk_sys);
    `CHK("six fails", 1'b0, latch_off)
    fail_once();
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("latched", 1'b1, latch_off)
    `CHK("retry over", 1'b0, retry_active)
    // Failures spread beyond the window do not latch
    do_reset();
    `CHK("reset unlatch", 1'b0, latch_off)
    host.rd_byte(8'h3D, q);
    `CHK("reset byte again", 8'h00, q)
    wait_retry();
    `CHK("retry again", 1'b1, retry_active)
    repeat (6) fail_once();
    repeat (210) @(negedge clk_sys);
    fail_once();
    repeat (4) @(negedge clk_sys);
    `CHK("window expired", 1'b0, latch_off)
    // Trip going away ends retry, disable bit drops a running retry
    uvp_trip_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("trip gone", 1'b0, retry_active)
    uvp_trip_pin = 1'b1;
    wait_retry();
    `CHK("retry third", 1'b1, retry_active)
    host.wr_byte(8'h3D, 8'h04);
    @(negedge clk_sys);
    `CHK("retry dropped", 1'b0, retry_active)
    uvp_trip_pin = 1'b0;
    report_and_stop();
  end

endmodule : tb_top

`default_nettype wire
